// ===== shared/bp_match_pkg.sv
package bp_match_pkg;
  // debug register selectors (5-bit)
  localparam logic [4:0] sel_attribute = 5'h06;
  localparam logic [4:0] sel_bound_high = 5'h0C;
  localparam logic [4:0] sel_bound_low = 5'h0D;
  localparam int selector_width = 5;
  // attribute register layout
  localparam int attr_width = 16;
  localparam logic [15:0] attr_reset = 16'h0005;
  localparam logic [31:0] bound_reset = 32'h00000000;
  localparam int rw_ignore_pos = 15;
  localparam int size_ignore_lsb = 13;
  localparam int type_ignore_lsb = 11;
  localparam int mod_ignore_lsb = 8;
  localparam int rw_pos = 7;
  localparam int size_lsb = 5;
  localparam int type_lsb = 3;
  localparam int mod_lsb = 0;
  // size encodings
  localparam logic [1:0] size_long = 2'h0;
  localparam logic [1:0] size_byte = 2'h1;
  localparam logic [1:0] size_word = 2'h2;
  // transfer type encodings
  localparam logic [1:0] type_normal = 2'h0;
  localparam logic [1:0] type_ext_dma = 2'h1;
  localparam logic [1:0] type_emulator = 2'h2;
  localparam logic [1:0] type_ack_cpu = 2'h3;
  // transfer modifier encodings
  localparam logic [2:0] mod_line_push = 3'h0;
  localparam logic [2:0] mod_user_a = 3'h1;
  localparam logic [2:0] mod_user_b = 3'h2;
  localparam logic [2:0] mod_super_data = 3'h5;
  localparam logic [2:0] mod_super_code = 3'h6;
  localparam logic [2:0] mod_cpu_space = 3'h0;

  // address compare modes chosen by the trigger logic
  typedef enum logic [1:0] {
    mode_exact,
    mode_inside,
    mode_outside
  } addr_mode_type;

  // decoded access class of the current transfer
  typedef enum logic [2:0] {
    class_reserved,
    class_line_push,
    class_user,
    class_super_data,
    class_super_code,
    class_emu_data,
    class_emu_code,
    class_cpu_space
  } access_class_type;

  // one local bus transfer
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic read_not_write;
    logic [1:0] size;
    logic [1:0] xfer_type;
    logic [2:0] xfer_mod;
  } bus_xfer_type;

  // register command (debug port or write-debug-control instruction)
  typedef struct packed {
    logic write;
    logic read;
    logic [4:0] selector;
    logic [31:0] wdata;
  } reg_cmd_type;

  // memory-command attributes taken from the attribute register
  typedef struct packed {
    logic [1:0] xfer_type;
    logic [2:0] xfer_mod;
  } mem_attr_type;
endpackage

// ===== rtl/access_class_decode.sv
`timescale 1ns/10ps
// combinational decode of transfer type and modifier into an access class
module access_class_decode
  import bp_match_pkg::*;
(
  input wire logic [1:0] xfer_type,
  input wire logic [2:0] xfer_mod,
  output access_class_type access_class
);
  // table per transfer type
  always_comb begin
    access_class = class_reserved;
    case (xfer_type)
      type_normal: begin
        case (xfer_mod) // [R10]
          mod_line_push: access_class = class_line_push;
          mod_user_a, mod_user_b: access_class = class_user;
          mod_super_data: access_class = class_super_data;
          mod_super_code: access_class = class_super_code;
          default: access_class = class_reserved;
        endcase
      end
      type_emulator: begin
        case (xfer_mod) // [R11]
          mod_super_data: access_class = class_emu_data;
          mod_super_code: access_class = class_emu_code;
          default: access_class = class_reserved;
        endcase
      end
      type_ack_cpu: begin
        // every modifier decodes to cpu space; the match block passes it out as ack_level
        access_class = class_cpu_space; // [R12]
      end
      default: access_class = class_reserved;
    endcase
  end
endmodule // access_class_decode

// ===== rtl/bus_attr_addr_breakpoint_match.sv
`timescale 1ns/10ps
// What this block does
// [R1] compare attribute register against each bus transfer
// [R2] bit 15 set ignores read/write
// [R3] bits 14-13 ignore matching size bits
// [R4] bits 12-11 ignore matching type bits
// [R5] bits 10-8 ignore matching modifier bits
// [R6] bit 7 compared with read-not-write
// [R7] bits 6-5 compared with bus size
// [R8] bits 4-3 compared with transfer type
// [R9] type field also drives memory command type
// [R10] normal mode modifier decode
// [R11] emulator mode modifier decode
// [R12] acknowledge mode: cpu space or level
// [R13] modifier field drives memory command modifier
// [R14] bounds compared with every transfer address
// [R15] exact mode matches low register only
// [R16] inside mode matches inclusive range
// [R17] outside mode matches below low or above high
// [R18] low register holds full 32-bit bound
// [R19] high register used only for ranges
// [R20] registers reached by 5-bit selector commands
// [R21] attribute selector 0x06, reset 0x0005
// [R22] low selector 0x0D, high 0x0C
// [R23] attribute match needs all unmasked bits equal
module bus_attr_addr_breakpoint_match
  import bp_match_pkg::*;
#(
  parameter int addr_width = 32
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bus_xfer_type xfer,
  input wire reg_cmd_type cmd,
  input wire addr_mode_type addr_mode,
  output logic attr_match,
  output logic addr_match,
  output logic match_valid,
  output access_class_type access_class,
  output logic [2:0] ack_level,
  output logic [31:0] read_data,
  output logic read_valid,
  output mem_attr_type mem_attr
);
  // refuse widths the comparator cannot serve
  initial begin
    if (addr_width != 32) begin
      $error("addr_width must be 32");
    end
  end

  // all block state
  typedef struct packed {
    logic [15:0] attribute_compare_value_mask;
    logic [31:0] address_bound_low;
    logic [31:0] address_bound_high;
    logic attr_match;
    logic addr_match;
    logic match_valid;
    access_class_type access_class;
    logic [2:0] ack_level;
    logic [31:0] read_data;
    logic read_valid;
  } state_type;

  state_type state;
  state_type next_state;
  access_class_type decoded_class; // from the decode leaf

  // unsigned compare, used by both range modes
  function automatic logic below(input logic [31:0] a, input logic [31:0] b);
    below = a < b;
  endfunction

  // attribute equality under a mask; set mask bits always compare equal
  function automatic logic masked_equal(input logic [7:0] want, input logic [7:0] got,
                                        input logic [7:0] ignore);
    masked_equal = ((want ^ got) & ~ignore) == 8'h00;
  endfunction

  // classify the live transfer
  access_class_decode u_decode (
    .xfer_type(xfer.xfer_type),
    .xfer_mod(xfer.xfer_mod),
    .access_class(decoded_class)
  );

  // next-state logic
  always_comb begin
    logic [7:0] attr_want;
    logic [7:0] attr_got;
    logic [7:0] attr_ignore;
    logic in_range;
    attr_want = 8'h00;
    attr_got = 8'h00;
    attr_ignore = 8'h00;
    in_range = 1'b0;
    next_state = state;
    next_state.read_valid = 1'b0;

    // register writes by selector
    if (cmd.write) begin // [R20]
      case (cmd.selector)
        sel_attribute: next_state.attribute_compare_value_mask = cmd.wdata[15:0]; // [R21]
        sel_bound_low: next_state.address_bound_low = cmd.wdata; // [R18] [R22]
        sel_bound_high: next_state.address_bound_high = cmd.wdata; // [R19] [R22]
        default: ;
      endcase
    end

    // register reads; unknown selectors read zero
    if (cmd.read) begin // [R20]
      next_state.read_valid = 1'b1;
      case (cmd.selector)
        sel_attribute: next_state.read_data = {16'h0000, state.attribute_compare_value_mask};
        sel_bound_low: next_state.read_data = state.address_bound_low;
        sel_bound_high: next_state.read_data = state.address_bound_high;
        default: next_state.read_data = 32'h00000000;
      endcase
    end

    // attribute compare: rw, size, type, modifier in the low byte
    attr_want = state.attribute_compare_value_mask[7:0]; // [R1]
    attr_got[rw_pos] = xfer.read_not_write; // [R6]
    attr_got[size_lsb +: 2] = xfer.size; // [R7]
    attr_got[type_lsb +: 2] = xfer.xfer_type; // [R8]
    attr_got[mod_lsb +: 3] = xfer.xfer_mod;
    attr_ignore[rw_pos] = state.attribute_compare_value_mask[rw_ignore_pos]; // [R2]
    attr_ignore[size_lsb +: 2] = state.attribute_compare_value_mask[size_ignore_lsb +: 2]; // [R3]
    attr_ignore[type_lsb +: 2] = state.attribute_compare_value_mask[type_ignore_lsb +: 2]; // [R4]
    attr_ignore[mod_lsb +: 3] = state.attribute_compare_value_mask[mod_ignore_lsb +: 3]; // [R5]

    // address compare on every transfer
    in_range = !below(xfer.addr, state.address_bound_low) &&
               !below(state.address_bound_high, xfer.addr); // [R14]

    // match results clear between transfers; access class and ack level are held
    next_state.match_valid = xfer.valid;
    if (xfer.valid) begin
      next_state.attr_match = masked_equal(attr_want, attr_got, attr_ignore); // [R23]
      next_state.access_class = decoded_class; // [R10] [R11] [R12]
      next_state.ack_level = (xfer.xfer_type == type_ack_cpu) ? xfer.xfer_mod : 3'h0; // [R12]
      case (addr_mode)
        mode_exact: next_state.addr_match = xfer.addr == state.address_bound_low; // [R15]
        mode_inside: next_state.addr_match = in_range; // [R16]
        mode_outside: next_state.addr_match = !in_range; // [R17]
        default: next_state.addr_match = 1'b0;
      endcase
    end else begin
      next_state.attr_match = 1'b0;
      next_state.addr_match = 1'b0;
    end

    // synchronous reset
    if (rst) begin
      next_state = '0;
      next_state.attribute_compare_value_mask = attr_reset; // [R21]
      next_state.address_bound_low = bound_reset;
      next_state.address_bound_high = bound_reset;
      next_state.access_class = class_reserved;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    state <= next_state;
  end

  // outputs straight from flip-flops
  assign attr_match = state.attr_match;
  assign addr_match = state.addr_match;
  assign match_valid = state.match_valid;
  assign access_class = state.access_class;
  assign ack_level = state.ack_level;
  assign read_data = state.read_data;
  assign read_valid = state.read_valid;
  // memory command attributes come from the stored fields
  assign mem_attr.xfer_type = state.attribute_compare_value_mask[type_lsb +: 2]; // [R9]
  assign mem_attr.xfer_mod = state.attribute_compare_value_mask[mod_lsb +: 3]; // [R13]
endmodule // bus_attr_addr_breakpoint_match

// ===== sim/bus_attr_addr_breakpoint_match_props.sv
`timescale 1ns/10ps
// watches match, ack level, memory attribute and register read outputs at the top ports; access_class is not checked
module bus_attr_addr_breakpoint_match_props
  import bp_match_pkg::*;
#(
  parameter int addr_width = 32
)(
  input wire logic ref_clk,
  input wire logic rst,
  input wire bus_xfer_type xfer,
  input wire reg_cmd_type cmd,
  input wire addr_mode_type addr_mode,
  input wire logic attr_match,
  input wire logic addr_match,
  input wire logic match_valid,
  input wire access_class_type access_class,
  input wire logic [2:0] ack_level,
  input wire logic [31:0] read_data,
  input wire logic read_valid,
  input wire mem_attr_type mem_attr
);
  logic [15:0] attr_q; // shadow of the attribute register
  logic [31:0] low_q; // shadow of the low bound
  logic [31:0] high_q; // shadow of the high bound
  logic exp_attr; // unmasked bits all equal
  logic exp_in; // address inside inclusive range
  // shadow registers follow accepted writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      attr_q <= attr_reset;
      low_q <= bound_reset;
      high_q <= bound_reset;
    end else if (cmd.write) begin
      if (cmd.selector == sel_attribute) attr_q <= cmd.wdata[15:0];
      if (cmd.selector == sel_bound_low) low_q <= cmd.wdata;
      if (cmd.selector == sel_bound_high) high_q <= cmd.wdata;
    end
  end
  assign exp_attr = (({xfer.read_not_write, xfer.size, xfer.xfer_type, xfer.xfer_mod} ^ attr_q[7:0])
    & ~attr_q[15:8]) == 8'h00;
  assign exp_in = (xfer.addr >= low_q) && (xfer.addr <= high_q);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_ATTR: assert property (xfer.valid |=> attr_match == $past(exp_attr)) else $error("attr match wrong");
  AST_EXACT:
    assert property (xfer.valid && addr_mode == mode_exact |=> addr_match == ($past(xfer.addr) ==
    $past(low_q))) else $error("exact match wrong");
  AST_INSIDE:
    assert property (xfer.valid && addr_mode == mode_inside |=> addr_match == $past(exp_in))
    else $error("inside match wrong");
  AST_OUTSIDE:
    assert property (xfer.valid && addr_mode == mode_outside |=> addr_match == !$past(exp_in))
    else $error("outside match wrong");
  AST_IDLE:
    assert property (!xfer.valid |=> !match_valid && !attr_match && !addr_match)
    else $error("match without transfer");
  AST_VALID: assert property (xfer.valid |=> match_valid) else $error("match_valid missing");
  AST_ACK:
    assert property (xfer.valid && xfer.xfer_type == type_ack_cpu |=> ack_level == $past(xfer.xfer_mod))
    else $error("ack level wrong");
  AST_MEM: assert property (mem_attr == attr_q[4:0]) else $error("mem attr wrong");
  AST_READ:
    assert property (cmd.read && cmd.selector == sel_attribute |=> read_valid &&
    read_data == {16'h0000, $past(attr_q)}) else $error("attr read wrong");
endmodule // bus_attr_addr_breakpoint_match_props
bind bus_attr_addr_breakpoint_match bus_attr_addr_breakpoint_match_props #(.addr_width(addr_width)) u_props (
  .ref_clk(ref_clk), .rst(rst), .xfer(xfer), .cmd(cmd), .addr_mode(addr_mode), .attr_match(attr_match),
  .addr_match(addr_match), .match_valid(match_valid), .access_class(access_class), .ack_level(ack_level),
  .read_data(read_data), .read_valid(read_valid), .mem_attr(mem_attr));

// ===== sim/local_bus_source.sv
`timescale 1ns/10ps
// core side: one local bus transfer per go cycle
module local_bus_source
  import bp_match_pkg::*;
(
  input wire logic ref_clk,
  input wire logic go,
  input wire bus_xfer_type req,
  output bus_xfer_type xfer
);
  initial xfer = '0;
  // idle address keeps toggling so a stale value never looks held
  always @(posedge ref_clk) begin
    if (go) begin
      xfer <= req;
    end else begin
      xfer.valid <= 1'b0;
      xfer.addr <= ~xfer.addr;
    end
  end
endmodule // local_bus_source

// ===== sim/test_bus_attr_addr_breakpoint_match.sv
`timescale 1ns/10ps
// register and transfer tests for the breakpoint match block
module test_bus_attr_addr_breakpoint_match;
  import bp_match_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0; // partner strobe
  logic hit; // expected address match
  bus_xfer_type req = '0;
  bus_xfer_type xfer;
  reg_cmd_type cmd = '0;
  addr_mode_type addr_mode = mode_exact;
  logic attr_match, addr_match, match_valid, read_valid;
  access_class_type access_class;
  logic [2:0] ack_level;
  logic [31:0] read_data;
  mem_attr_type mem_attr;
  int n_errors = 0;
  int total_checks = 0;
  logic [31:0] ad [4] = '{32'h80000FFF, 32'h80001000, 32'h80001FFF, 32'h80002000};
  logic [4:0] tm [10] = '{5'h00, 5'h01, 5'h02, 5'h05, 5'h06, 5'h03, 5'h15, 5'h16, 5'h14, 5'h18};
  access_class_type cl [10] = '{class_line_push, class_user, class_user, class_super_data, class_super_code,
    class_reserved, class_emu_data, class_emu_code, class_reserved, class_cpu_space};
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  bus_attr_addr_breakpoint_match u_bus_attr_addr_breakpoint_match (.ref_clk(ref_clk), .rst(rst), .xfer(xfer),
    .cmd(cmd), .addr_mode(addr_mode), .attr_match(attr_match), .addr_match(addr_match), .match_valid(match_valid),
    .access_class(access_class), .ack_level(ack_level), .read_data(read_data), .read_valid(read_valid),
    .mem_attr(mem_attr));
  local_bus_source u_local_bus_source (.ref_clk(ref_clk), .go(go), .req(req), .xfer(xfer));
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one register write command
  task automatic reg_wr(input logic [4:0] sel, input logic [31:0] d);
    @(posedge ref_clk) cmd <= '{1'b1, 1'b0, sel, d};
    @(posedge ref_clk) cmd <= '0;
  endtask
  // one register read command, answer one cycle later
  task automatic reg_rd(input logic [4:0] sel, input logic [31:0] exp);
    @(posedge ref_clk) cmd <= '{1'b0, 1'b1, sel, 32'h00000000};
    @(posedge ref_clk) cmd <= '0;
    #1;
    chk("read_valid", 32'h1, 32'(read_valid));
    chk("read_data", exp, read_data);
  endtask
  // one transfer through the partner, outputs settled on return
  task automatic bus(input logic [31:0] a, input logic [7:0] at, input addr_mode_type m);
    @(posedge ref_clk) go <= 1'b1;
    req <= {1'b1, a, at};
    addr_mode <= m;
    @(posedge ref_clk) go <= 1'b0;
    @(posedge ref_clk) #1;
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    finish_test;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    reg_rd(sel_attribute, 32'h00000005);
    reg_rd(5'h07, 32'h00000000);
    chk("mem_attr", 32'h05, 32'(mem_attr));
    $display("reset test done");
    reg_wr(sel_bound_low, 32'h80001000);
    reg_wr(sel_bound_high, 32'h80001FFF);
    reg_wr(5'h01, 32'h12345678);
    reg_rd(sel_bound_low, 32'h80001000);
    reg_rd(sel_bound_high, 32'h80001FFF);
    for (int i = 0; i < 4; i++) begin
      for (int m = 0; m < 3; m++) begin
        bus(ad[i], 8'h95, addr_mode_type'(m));
        hit = (m == 0) ? (i == 1) : ((m == 1) == (i == 1 || i == 2));
        chk("addr_match", 32'(hit), 32'(addr_match));
        chk("match_valid", 32'h1, 32'(match_valid));
      end
    end
    $display("address test done");
    for (int b = 0; b < 8; b++) begin
      reg_wr(sel_attribute, 32'h00000095);
      bus(32'h0, 8'h95 ^ (8'h01 << b), mode_exact);
      chk("attr_miss", 32'h0, 32'(attr_match));
      reg_wr(sel_attribute, 32'h00000095 | (32'h00000100 << b));
      bus(32'h0, 8'h95 ^ (8'h01 << b), mode_exact);
      chk("attr_masked", 32'h1, 32'(attr_match));
    end
    reg_rd(sel_attribute, 32'h00008095);
    chk("mem_attr", 32'h15, 32'(mem_attr));
    $display("attribute test done");
    for (int i = 0; i < 10; i++) begin
      bus(32'h0, {3'h0, tm[i]}, mode_exact);
      chk("access_class", 32'(cl[i]), 32'(access_class));
    end
    for (int l = 1; l < 8; l++) begin
      bus(32'h0, {3'h0, type_ack_cpu, 3'(l)}, mode_exact);
      chk("ack_level", 32'(l), 32'(ack_level));
    end
    $display("decode test done");
    finish_test;
  end
endmodule // test_bus_attr_addr_breakpoint_match
